// file: common/hbv_cfg.svh
// Constants for the host bus and interrupt vector unit
`ifndef HBV_CFG_SVH
`define HBV_CFG_SVH

`define HBV_NUM_CHAN     16
`define HBV_REG_VECTOR   5'h17
`define HBV_VEC_RESET    8'h0F
`define HBV_VEC_UP_HI    7
`define HBV_VEC_UP_LO    4
`define HBV_VEC_SVC_BIT  3
`define HBV_CLK_MHZ      50
`define HBV_RST_MIN_NS   2000
`define HBV_RST_MIN_CYC  ((`HBV_RST_MIN_NS * `HBV_CLK_MHZ + 999) / 1000)

`endif

// file: common/hbv_pkg.sv
// Types for the host bus and interrupt vector unit
package hbv_pkg;

  typedef logic [15:0] hbv_chan_t;
  typedef logic [7:0]  hbv_byte_t;
  typedef logic [4:0]  hbv_sel_t;
  typedef logic [3:0]  hbv_code_t;

  typedef enum logic [2:0] {
    HBV_IDLE,
    HBV_LOAD,
    HBV_HOLD,
    HBV_NEG,
    HBV_PASS
  } hbv_state_t;

endpackage : hbv_pkg

// file: design/hbv_prio_enc.sv
// Fixed priority encoder over the interrupt channels
`timescale 1ns/1ns

module hbv_prio_enc
  import hbv_pkg::*;
(
  input  wire hbv_pkg::hbv_chan_t req,
  output logic                    valid,
  output hbv_pkg::hbv_code_t      code
);

  // Highest index wins, code equals index
  always_comb begin
    valid = 1'b0;
    code  = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (req[i]) begin
        valid = 1'b1;
        code  = hbv_code_t'(i);
      end
    end
  end

endmodule : hbv_prio_enc

// file: design/hbv_unit.sv
// Host bus slave with interrupt acknowledge and vector logic
`timescale 1ns/1ns
`include "hbv_cfg.svh"

module hbv_unit (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               chipSelN,
  input  wire logic               dataStrobeN,
  input  wire logic               readHighWriteLow,
  input  wire hbv_pkg::hbv_sel_t  regSelect,
  input  wire hbv_pkg::hbv_byte_t dataIn,
  output hbv_pkg::hbv_byte_t      dataOut,
  output logic                    dataOe,
  output logic                    xferAckN,
  output logic                    xferAckOe,
  input  wire logic               intrAckN,
  input  wire logic               chainEnableInN,
  output logic                    chainEnableOutN,
  output logic                    intReqN,
  output logic                    intReqOe,
  input  wire hbv_pkg::hbv_chan_t chanPending,
  input  wire hbv_pkg::hbv_chan_t chanUnmasked,
  input  wire hbv_pkg::hbv_chan_t isrClear,
  output hbv_pkg::hbv_chan_t      pendClear,
  output hbv_pkg::hbv_chan_t      inService,
  output logic                    svcEnable
);

  import hbv_pkg::*;

  localparam hbv_byte_t vecResetVal = `HBV_VEC_RESET;

  hbv_state_t state;
  logic       inIack;
  hbv_code_t  vecUpper;
  hbv_chan_t  clrSent;
  hbv_chan_t  effReq;
  hbv_chan_t  winMask;
  hbv_code_t  winCode;
  hbv_byte_t  regRead;
  logic       anyPend;
  logic       busReq;
  logic       iackReq;
  logic       busEnd;
  logic       iackEnd;
  logic       endNow;
  logic       rdStart;
  logic       wrStart;
  logic       vecStart;
  logic       passStart;
  logic       vecHit;

  // Strobe decode
  assign busReq   = !chipSelN && !dataStrobeN && intrAckN;
  assign iackReq  = !intrAckN && !dataStrobeN;
  assign busEnd   = chipSelN || dataStrobeN;
  assign iackEnd  = dataStrobeN || intrAckN;
  assign endNow   = inIack ? iackEnd : busEnd;

  // Cycle starts, taken only from idle
  assign rdStart   = (state == HBV_IDLE) && busReq && readHighWriteLow;
  assign wrStart   = (state == HBV_IDLE) && busReq && !readHighWriteLow;
  assign vecStart  = (state == HBV_IDLE) && !busReq && iackReq
                     && !chainEnableInN && anyPend;
  assign passStart = (state == HBV_IDLE) && !busReq && iackReq
                     && !chainEnableInN && !anyPend;

  assign vecHit = (regSelect == `HBV_REG_VECTOR);

  // Already acknowledged channels stay out until their pending drops
  assign effReq  = chanPending & chanUnmasked & ~clrSent;
  assign winMask = hbv_chan_t'(1) << winCode;

  hbv_prio_enc uPrio (
    .req   (effReq),
    .valid (anyPend),
    .code  (winCode)
  );

  // Read data, low bits of the vector register read zero
  always_comb begin
    regRead = 8'h00;
    if (vecHit) begin
      regRead = {vecUpper, svcEnable, 3'b000};
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state  <= HBV_IDLE;
      inIack <= 1'b0;
    end else begin
      case (state)
        HBV_IDLE: begin
          if (rdStart || wrStart) begin
            inIack <= 1'b0;
            state  <= HBV_LOAD;
          end else if (vecStart) begin
            inIack <= 1'b1;
            state  <= HBV_LOAD;
          end else if (passStart) begin
            inIack <= 1'b1;
            state  <= HBV_PASS;
          end
        end
        HBV_LOAD: begin
          state <= HBV_HOLD;
        end
        HBV_HOLD: begin
          if (endNow) begin
            state <= HBV_NEG;
          end
        end
        HBV_NEG: begin
          state <= HBV_IDLE;
        end
        HBV_PASS: begin
          if (iackEnd) begin
            state <= HBV_IDLE;
          end
        end
        default: begin
          state <= HBV_IDLE;
        end
      endcase
    end
  end

  // Data bus drive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataOut <= 8'h00;
      dataOe  <= 1'b0;
    end else if (rdStart) begin
      dataOut <= regRead;
      dataOe  <= 1'b1;
    end else if (vecStart) begin
      dataOut <= {vecUpper, winCode};
      dataOe  <= 1'b1;
    end else if (state == HBV_HOLD && endNow) begin
      dataOe  <= 1'b0;
    end
  end

  // Transfer acknowledge, driven high before release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xferAckN  <= 1'b1;
      xferAckOe <= 1'b0;
    end else begin
      case (state)
        HBV_LOAD: begin
          xferAckN  <= 1'b0;
          xferAckOe <= 1'b1;
        end
        HBV_HOLD: begin
          if (endNow) begin
            xferAckN <= 1'b1;
          end
        end
        HBV_NEG: begin
          xferAckOe <= 1'b0;
        end
        default: begin
          xferAckN <= 1'b1;
        end
      endcase
    end
  end

  // Daisy chain output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chainEnableOutN <= 1'b1;
    end else if (passStart) begin
      chainEnableOutN <= 1'b0;
    end else if (state == HBV_PASS && iackEnd) begin
      chainEnableOutN <= 1'b1;
    end
  end

  // Vector register, loaded at the start of a write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      vecUpper  <= vecResetVal[`HBV_VEC_UP_HI:`HBV_VEC_UP_LO];
      svcEnable <= vecResetVal[`HBV_VEC_SVC_BIT];
    end else if (wrStart && vecHit) begin
      vecUpper  <= dataIn[`HBV_VEC_UP_HI:`HBV_VEC_UP_LO];
      svcEnable <= dataIn[`HBV_VEC_SVC_BIT];
    end
  end

  // Pending clear pulse to the acknowledged channel
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pendClear <= 16'h0000;
    end else if (vecStart) begin
      pendClear <= winMask;
    end else begin
      pendClear <= 16'h0000;
    end
  end

  // Channels waiting for their pending bit to fall, set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clrSent <= 16'h0000;
    end else if (vecStart) begin
      clrSent <= (clrSent & chanPending) | winMask;
    end else begin
      clrSent <= clrSent & chanPending;
    end
  end

  // In-service bits, forced low in automatic mode, set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inService <= 16'h0000;
    end else if (!svcEnable) begin
      inService <= 16'h0000;
    end else if (vecStart) begin
      inService <= (inService & ~isrClear) | winMask;
    end else begin
      inService <= inService & ~isrClear;
    end
  end

  // Open-drain interrupt request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intReqN  <= 1'b1;
      intReqOe <= 1'b0;
    end else begin
      intReqN  <= !(|effReq);
      intReqOe <= |effReq;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seqAckLow;
    !xferAckN && xferAckOe;
  endsequence

  sequence seqAckRelease;
    xferAckN && xferAckOe ##1 !xferAckOe;
  endsequence

  sequence seqDataThenAck;
    dataOe && xferAckN ##1 (dataOe and seqAckLow);
  endsequence

  chk_read_data_first: assert property (
    rdStart |=> seqDataThenAck
  ) else $error("read acknowledge not preceded by data");

  chk_write_load: assert property (
    (wrStart && vecHit) |=> (vecUpper == $past(dataIn[7:4])) && xferAckN
                            ##1 seqAckLow
  ) else $error("write did not load before acknowledge");

  chk_bus_end_release: assert property (
    (state == HBV_HOLD && !inIack && busEnd) |=> seqAckRelease
  ) else $error("bus cycle end did not release acknowledge");

  chk_intr_ack_n_end_release: assert property (
    (state == HBV_HOLD && inIack && iackEnd) |=> (!dataOe and seqAckRelease)
  ) else $error("acknowledge end did not release bus");

  chk_irq_follows: assert property (
    (|effReq) |=> !intReqN && intReqOe
  ) else $error("pending interrupt not requested");

  chk_vector_value: assert property (
    vecStart |=> dataOe && dataOut == {$past(vecUpper), $past(winCode)}
  ) else $error("wrong vector on data bus");

  chk_pass_silent: assert property (
    passStart |=> (!chainEnableOutN && !dataOe && !xferAckOe)
                  throughout (state == HBV_PASS)
  ) else $error("drive seen while passing priority");

  chk_chain_block: assert property (
    (state == HBV_IDLE && chainEnableInN) |=> chainEnableOutN && !dataOe
  ) else $error("acted with chain input high");

  chk_pend_clear: assert property (
    vecStart |=> pendClear == (hbv_chan_t'(1) << $past(winCode))
                 ##1 pendClear == 16'h0000
  ) else $error("pending clear pulse wrong");

  chk_irq_after_ack: assert property (
    (vecStart && $onehot(effReq)) |=> ##1 intReqN
  ) else $error("request not negated after acknowledge");

  chk_isr_auto: assert property (
    !svcEnable |=> inService == 16'h0000
  ) else $error("in-service bits set in automatic mode");

endmodule : hbv_unit

// file: tb/hbv_host_model.sv
// Host bus master model running strobed cycles
`timescale 1ns/1ns
module hbv_host_model (
  input  wire logic               clock,
  output logic                    chipSelN,
  output logic                    dataStrobeN,
  output logic                    readHighWriteLow,
  output logic                    intrAckN,
  output hbv_pkg::hbv_sel_t       regSelect,
  output hbv_pkg::hbv_byte_t      dataIn,
  input  wire hbv_pkg::hbv_byte_t dataOut,
  input  wire logic               dataOe,
  input  wire logic               xferAckN,
  input  wire logic               xferAckOe,
  input  wire logic               chainEnableOutN,
  input  wire hbv_pkg::hbv_chan_t pendClear
);
  import hbv_pkg::*;
  hbv_chan_t pendSeen;
  logic      gotAck;
  logic      gotOe;
  logic      gotPass;
  logic      busy;
  initial begin
    chipSelN = 1'b1;
    dataStrobeN = 1'b1;
    intrAckN = 1'b1;
    readHighWriteLow = 1'b1;
    regSelect = 5'h00;
    dataIn = 8'hFF;
  end
  task automatic cycle(input logic isAck, input logic rd, input hbv_sel_t sel,
                       input hbv_byte_t wd, output hbv_byte_t rdat);
    gotAck = 1'b0;
    gotOe = 1'b0;
    gotPass = 1'b0;
    busy = 1'b0;
    pendSeen = 16'h0000;
    rdat = 8'h00;
    @(posedge clock);
    #1;
    regSelect = sel;
    dataIn = wd;
    readHighWriteLow = rd;
    chipSelN = isAck;
    intrAckN = !isAck;
    dataStrobeN = 1'b0;
    for (int n = 0; n < 10; n++) begin
      @(posedge clock);
      pendSeen |= pendClear;
      if (chainEnableOutN === 1'b0) begin
        gotPass = 1'b1;
        busy = dataOe | xferAckOe;
        break;
      end
      if (xferAckOe === 1'b1 && xferAckN === 1'b0) begin
        gotAck = 1'b1;
        gotOe = dataOe;
        rdat = dataOut;
        break;
      end
    end
    #1;
    chipSelN = 1'b1;
    dataStrobeN = 1'b1;
    intrAckN = 1'b1;
    dataIn = ~wd;
    repeat (3) @(posedge clock);
  endtask : cycle
endmodule : hbv_host_model

// file: tb/tb_top.sv
// Testbench for the host bus and interrupt vector unit
`timescale 1ns/1ns
`include "hbv_cfg.svh"
module tb_top;
  import hbv_pkg::*;
  logic      clock, rst, chipSelN, dataStrobeN, readHighWriteLow, intrAckN;
  logic      dataOe, xferAckN, xferAckOe, chainEnableInN, chainEnableOutN;
  logic      intReqN, intReqOe, svcEnable;
  hbv_sel_t  regSelect;
  hbv_byte_t dataIn, dataOut, d;
  hbv_chan_t chanPending, chanUnmasked, isrClear, pendClear, inService;
  int        fail_count = 0;
  int        num_checks = 0;
  hbv_unit hbv_unit_inst (.clock(clock), .rst(rst), .chipSelN(chipSelN),
    .dataStrobeN(dataStrobeN), .readHighWriteLow(readHighWriteLow), .regSelect(regSelect),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .xferAckN(xferAckN),
    .xferAckOe(xferAckOe), .intrAckN(intrAckN), .chainEnableInN(chainEnableInN),
    .chainEnableOutN(chainEnableOutN), .intReqN(intReqN), .intReqOe(intReqOe),
    .chanPending(chanPending), .chanUnmasked(chanUnmasked), .isrClear(isrClear),
    .pendClear(pendClear), .inService(inService), .svcEnable(svcEnable));
  hbv_host_model hbv_host_model_inst (.clock(clock), .chipSelN(chipSelN),
    .dataStrobeN(dataStrobeN), .readHighWriteLow(readHighWriteLow), .intrAckN(intrAckN),
    .regSelect(regSelect), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .xferAckN(xferAckN), .xferAckOe(xferAckOe), .chainEnableOutN(chainEnableOutN),
    .pendClear(pendClear));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic rd(input hbv_sel_t s);
    hbv_host_model_inst.cycle(1'b0, 1'b1, s, 8'h00, d);
  endtask : rd
  task automatic wr(input hbv_sel_t s, input hbv_byte_t v);
    hbv_host_model_inst.cycle(1'b0, 1'b0, s, v, d);
  endtask : wr
  task automatic ack(input hbv_byte_t v, input hbv_chan_t pc);
    hbv_host_model_inst.cycle(1'b1, 1'b1, 5'h00, 8'h00, d);
    check("vector", 16'(d), 16'(v));
    check("vecOe", 16'(hbv_host_model_inst.gotOe), 16'h0001);
    check("pendClr", hbv_host_model_inst.pendSeen, pc);
    check("endOe", 16'({dataOe, xferAckOe}), 16'h0000);
  endtask : ack
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #300000;
    fail_count++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    chainEnableInN = 1'b0;
    chanPending = 16'h0000;
    chanUnmasked = 16'h0000;
    isrClear = 16'h0000;
    step(`HBV_RST_MIN_CYC);
    rst = 1'b0;
    check("rstOut", 16'({xferAckOe, dataOe, chainEnableOutN, intReqOe}), 16'h0002);
    check("rstIsr", inService, 16'h0000);
    rd(5'h03);
    rd(5'h17);
    check("vecRst", 16'(d), 16'h0008);
    check("rdOe", 16'(hbv_host_model_inst.gotOe), 16'h0001);
    check("endOe", 16'({dataOe, xferAckOe}), 16'h0000);
    wr(5'h17, 8'hAF);
    wr(5'h03, 8'hFF);
    rd(5'h03);
    check("unmap", 16'(d), 16'h0000);
    rd(5'h17);
    check("vecWr", 16'(d), 16'h00A8);
    check("svc", 16'(svcEnable), 16'h0001);
    step(1);
    chanUnmasked = 16'h00FF;
    chanPending = 16'h8030;
    step(2);
    check("req", 16'(intReqN), 16'h0000);
    ack(8'hA5, 16'h0020);
    check("isr", inService, 16'h0020);
    check("reqMore", 16'(intReqN), 16'h0000);
    step(1);
    chanPending = 16'h8010;
    ack(8'hA4, 16'h0010);
    check("reqDone", 16'(intReqN), 16'h0001);
    step(1);
    isrClear = 16'h0020;
    step(1);
    isrClear = 16'h0000;
    step(1);
    check("isrClr", inService, 16'h0010);
    chanPending = 16'h8004;
    step(2);
    check("reqOn", 16'(intReqN), 16'h0000);
    chanUnmasked = 16'h00FB;
    step(2);
    check("reqMask", 16'(intReqN), 16'h0001);
    hbv_host_model_inst.cycle(1'b1, 1'b1, 5'h00, 8'h00, d);
    check("pass", 16'(hbv_host_model_inst.gotPass), 16'h0001);
    check("passBusy", 16'(hbv_host_model_inst.busy), 16'h0000);
    check("passAck", 16'(hbv_host_model_inst.gotAck), 16'h0000);
    step(1);
    chanUnmasked = 16'hFFFF;
    chainEnableInN = 1'b1;
    hbv_host_model_inst.cycle(1'b1, 1'b1, 5'h00, 8'h00, d);
    check("blockAck", 16'(hbv_host_model_inst.gotAck), 16'h0000);
    check("blockPass", 16'(hbv_host_model_inst.gotPass), 16'h0000);
    step(1);
    chainEnableInN = 1'b0;
    ack(8'hAF, 16'h8000);
    wr(5'h17, 8'h50);
    check("svcOff", 16'(svcEnable), 16'h0000);
    check("isrAuto", inService, 16'h0000);
    step(1);
    chanPending = 16'h0001;
    ack(8'h50, 16'h0001);
    check("isrOff", inService, 16'h0000);
    conclude();
  end
endmodule : tb_top
